// ### core/burst_router.sv
/*
 * Burst step index and target address generation.
 * Assumes one step pulse per accepted access of the burst data register.
 */
`default_nettype none
`include "tmr_consts.svh"
module burst_router (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic step,
    input wire logic byte_mode,
    input wire logic [4:0] base,
    input wire logic [4:0] len,
    output logic [7:0] tgt_a,
    output logic [7:0] tgt_b,
    output logic b_ok
);
    logic [5:0] idx_r;
    logic [5:0] idx_nxt;
    logic [5:0] total;

    function automatic logic [7:0] word_addr(input logic [5:0] w);
        return 8'(`TMR_OFF_CTRL1) + {w, 2'b00};
    endfunction

    assign total = {1'b0, len} + 6'h01;
    assign tgt_a = word_addr({1'b0, base} + idx_r);
    assign tgt_b = word_addr({1'b0, base} + idx_r + 6'h01);
    assign b_ok = byte_mode && (idx_r + 6'h01 < total);

    always_comb
    begin
        idx_nxt = idx_r + (byte_mode ? 6'h02 : 6'h01);
        if (idx_nxt >= total)
            idx_nxt = 6'h00;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idx_r <= 6'h00;
        else if (restart)
            idx_r <= 6'h00;
        else if (step)
            idx_r <= idx_nxt;
    end

    burst_wrap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (step && !restart && !byte_mode && idx_r == {1'b0, len})
        |=> idx_r == 6'h00)
        else $error("burst did not wrap after length plus one steps");

    burst_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (step && !restart && !byte_mode && idx_r < {1'b0, len})
        |=> idx_r == $past(idx_r) + 6'h01)
        else $error("burst index did not advance on a step");
endmodule // burst_router
`default_nettype wire

// ### core/compare_channel.sv
/*
 * One capture/compare channel: stored value, active compare value
 * and registered compare output.
 * Assumes a synchronised capture edge and a one-cycle update pulse.
 */
`default_nettype none
module compare_channel #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic input_mode,
    input wire logic preload_en,
    input wire logic update_evt,
    input wire logic capture_evt,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    input wire logic [W-1:0] count,
    output logic [W-1:0] value,
    output logic event_r,
    output logic out_r
);
    logic [W-1:0] value_r;
    logic [W-1:0] active_r;

    assign value = value_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_r <= '0;
        else if (input_mode && capture_evt)
            value_r <= count;
        else if (wr_en)
            value_r <= wr_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_r <= '0;
        else if (!input_mode && wr_en && !preload_en)
            active_r <= wr_data;
        else if (!input_mode && update_evt)
            active_r <= value_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            event_r <= 1'b0;
            out_r <= 1'b0;
        end
        else
        begin
            event_r <= input_mode ? capture_evt : (count == active_r);
            out_r <= !input_mode && (count < active_r);
        end
    end

    capture_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (input_mode && capture_evt) |=> value_r == $past(count))
        else $error("capture did not load the counter value");

    direct_apply_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!input_mode && wr_en && !preload_en) |=> active_r == $past(wr_data))
        else $error("direct compare write not applied at once");

    preload_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!input_mode && preload_en && !update_evt) |=> $stable(active_r))
        else $error("preloaded compare value applied before update");

    compare_out_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !input_mode
        |=> out_r == ($past(count) < $past(active_r)))
        else $error("compare output does not follow the comparison");
endmodule // compare_channel
`default_nettype wire

// ### core/timer_regs.sv
/*
 * Timer reload, capture/compare and burst control registers on APB,
 * with a small counter, four channels and an interrupt output.
 * Assumes an APB master on pclk and asynchronous capture pins.
 */
// Design decision made here: the APB interface to the registers.
// What this block does
// - Counter stays halted while the reload value is zero.
// - Upper halves of reload and channel values exist only on wide instances.
// - Input channel stores counter value at its latest capture edge.
// - Output channel compares active value with counter to drive its output.
// - Without preload a written compare value applies immediately.
// - With preload a written value applies at the next update event.
// - Channels two to four behave like channel one at own offsets.
// - Five-bit base field picks first burst register as word offset.
// - Five-bit length field gives field plus one transfers per burst in sixteen-bit mode, half that rounded up in eight-bit mode.
// - Each burst data access performs one burst step.
// - Step target is control one plus base plus running index.
// - Sixteen-bit burst data goes whole to each successive register.
// - Eight-bit burst data splits high then low over two registers.
`default_nettype none
`include "tmr_consts.svh"
module timer_regs
    import tmr_types_pkg::*;
#(
    parameter bit WIDE_TIMER = 1'b0,
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] capture_in,
    output logic [3:0] channel_out,
    output logic irq
);
    import tmr_types_pkg::*;

    localparam int W = WIDE_TIMER ? 32 : 16;
    localparam logic [31:0] RELOAD_RST = `TMR_RELOAD_RST;

    bus_state_t state_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic [1:0] ctrl1_r;
    logic [31:0] mode_r;
    logic [4:0] mask_r;
    logic [4:0] status_r;
    logic [4:0] status_nxt;
    logic [W-1:0] count_r;
    logic [W-1:0] reload_r;
    logic [15:0] dctrl_r;
    logic [3:0] cap_s1_r;
    logic [3:0] cap_s2_r;
    logic [3:0] cap_s3_r;
    logic [3:0] cap_edge;
    logic [3:0] ch_event;
    logic [3:0] ch_out;
    logic [W-1:0] cc_val [4];
    logic [7:0] addr;
    logic acc;
    logic is_burst;
    logic byte_mode;
    logic [7:0] tgt_a;
    logic [7:0] tgt_b;
    logic b_ok;
    logic wa_en;
    logic [7:0] wa_addr;
    logic [31:0] wa_data;
    logic wb_en;
    logic [7:0] wb_addr;
    logic [31:0] wb_data;
    logic run;
    logic upd;
    logic [31:0] read_data;
    logic [31:0] rd_a;
    logic [31:0] rd_b;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign channel_out = ch_out;

    function automatic logic hit(input logic en, input logic [7:0] a,
        input logic [7:0] off);
        return en && (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `TMR_OFF_CTRL1, `TMR_OFF_MASK, `TMR_OFF_STATUS, `TMR_OFF_MODE,
            `TMR_OFF_COUNT, `TMR_OFF_RELOAD, `TMR_OFF_CC1, `TMR_OFF_CC2,
            `TMR_OFF_CC3, `TMR_OFF_CC4, `TMR_OFF_DCTRL, `TMR_OFF_DATA:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] rd(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h00000000;
        case (a)
            `TMR_OFF_CTRL1: d = {30'h0, ctrl1_r};
            `TMR_OFF_MASK: d = {27'h0, mask_r};
            `TMR_OFF_STATUS: d = {27'h0, status_r};
            `TMR_OFF_MODE: d = mode_r;
            `TMR_OFF_COUNT: d = 32'(count_r);
            `TMR_OFF_RELOAD: d = 32'(reload_r);
            `TMR_OFF_CC1: d = 32'(cc_val[0]);
            `TMR_OFF_CC2: d = 32'(cc_val[1]);
            `TMR_OFF_CC3: d = 32'(cc_val[2]);
            `TMR_OFF_CC4: d = 32'(cc_val[3]);
            `TMR_OFF_DCTRL: d = {16'h0, dctrl_r};
            default: d = 32'h00000000;
        endcase
        return d;
    endfunction

    // Bus decode and burst redirection
    assign addr = paddr[7:0];
    assign acc = (state_r == BUS_ANSWER) && psel && penable &&
        (paddr[ADDR_W-1:8] == '0);
    assign is_burst = (addr == `TMR_OFF_DATA);
    assign byte_mode = ctrl1_r[`TMR_CTRL1_BYTE_BIT];
    assign wa_en = acc && pwrite;
    assign wa_addr = is_burst ? tgt_a : addr;
    assign wa_data = !is_burst ? pwdata :
        byte_mode ? {24'h0, pwdata[15:8]} : {16'h0, pwdata[15:0]};
    assign wb_en = acc && pwrite && is_burst && b_ok;
    assign wb_addr = tgt_b;
    assign wb_data = {24'h0, pwdata[7:0]};

    burst_router u_burst (
        .pclk(pclk),
        .presetn(presetn),
        .restart(hit(wa_en, addr, `TMR_OFF_DCTRL)),
        .step(acc && is_burst),
        .byte_mode(byte_mode),
        .base(dctrl_r[`TMR_BASE_MSB:`TMR_BASE_LSB]),
        .len(dctrl_r[`TMR_LEN_MSB:`TMR_LEN_LSB]),
        .tgt_a(tgt_a),
        .tgt_b(tgt_b),
        .b_ok(b_ok)
    );

    always_comb
    begin
        rd_a = rd(tgt_a);
        rd_b = b_ok ? rd(tgt_b) : 32'h00000000;
        if (paddr[ADDR_W-1:8] != '0)
            read_data = 32'h00000000;
        else if (!is_burst)
            read_data = rd(addr);
        else if (byte_mode)
            read_data = {16'h0, rd_a[7:0], rd_b[7:0]};
        else
            read_data = {16'h0, rd_a[15:0]};
    end

    // APB slave: one wait state, answer from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= BUS_SETUP;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            case (state_r)
                BUS_SETUP:
                    if (psel && penable)
                    begin
                        state_r <= BUS_ANSWER;
                        pready_r <= 1'b1;
                        pslverr_r <= !mapped(addr) ||
                            (paddr[ADDR_W-1:8] != '0);
                        prdata_r <= pwrite ? 32'h00000000 : read_data;
                    end
                BUS_ANSWER:
                begin
                    state_r <= BUS_SETUP;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
                default:
                begin
                    state_r <= BUS_SETUP;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
            endcase
        end
    end

    // Software-written control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl1_r <= 2'b00;
            mode_r <= 32'h00000000;
            mask_r <= 5'h00;
            dctrl_r <= `TMR_DCTRL_RST;
        end
        else
        begin
            if (hit(wa_en, wa_addr, `TMR_OFF_CTRL1))
                ctrl1_r <= wa_data[1:0];
            else if (hit(wb_en, wb_addr, `TMR_OFF_CTRL1))
                ctrl1_r <= wb_data[1:0];
            if (hit(wa_en, wa_addr, `TMR_OFF_MODE))
                mode_r <= wa_data & `TMR_MODE_MASK;
            else if (hit(wb_en, wb_addr, `TMR_OFF_MODE))
                mode_r <= wb_data & `TMR_MODE_MASK;
            if (hit(wa_en, wa_addr, `TMR_OFF_MASK))
                mask_r <= wa_data[4:0];
            else if (hit(wb_en, wb_addr, `TMR_OFF_MASK))
                mask_r <= wb_data[4:0];
            if (hit(wa_en, wa_addr, `TMR_OFF_DCTRL))
                dctrl_r <= wa_data[15:0] & `TMR_DCTRL_MASK;
            else if (hit(wb_en, wb_addr, `TMR_OFF_DCTRL))
                dctrl_r <= wb_data[15:0] & `TMR_DCTRL_MASK;
        end
    end

    // Reload value, only W bits kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reload_r <= RELOAD_RST[W-1:0];
        else if (hit(wa_en, wa_addr, `TMR_OFF_RELOAD))
            reload_r <= wa_data[W-1:0];
        else if (hit(wb_en, wb_addr, `TMR_OFF_RELOAD))
            reload_r <= wb_data[W-1:0];
    end

    // Up counter with update event at the reload value
    assign run = ctrl1_r[`TMR_CTRL1_RUN_BIT] && (reload_r != '0);
    assign upd = run && (count_r == reload_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= '0;
        else if (hit(wa_en, wa_addr, `TMR_OFF_COUNT))
            count_r <= wa_data[W-1:0];
        else if (hit(wb_en, wb_addr, `TMR_OFF_COUNT))
            count_r <= wb_data[W-1:0];
        else if (upd)
            count_r <= '0;
        else if (run)
            count_r <= count_r + 1'b1;
    end

    // Capture pins: two-stage sync then edge stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_s1_r <= 4'h0;
            cap_s2_r <= 4'h0;
            cap_s3_r <= 4'h0;
        end
        else
        begin
            cap_s1_r <= capture_in;
            cap_s2_r <= cap_s1_r;
            cap_s3_r <= cap_s2_r;
        end
    end

    assign cap_edge = cap_s2_r & ~cap_s3_r;

    for (genvar k = 0; k < 4; k++)
    begin : g_ch
        localparam logic [7:0] OFF = 8'(`TMR_OFF_CC1 + 4 * k);
        compare_channel #(
            .W(W)
        ) u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .input_mode(mode_r[k * `TMR_MODE_STRIDE + `TMR_MODE_IN_BIT]),
            .preload_en(mode_r[k * `TMR_MODE_STRIDE + `TMR_MODE_PRE_BIT]),
            .update_evt(upd),
            .capture_evt(cap_edge[k]),
            .wr_en(hit(wa_en, wa_addr, OFF) ||
                hit(wb_en, wb_addr, OFF)),
            .wr_data(hit(wa_en, wa_addr, OFF) ?
                wa_data[W-1:0] : wb_data[W-1:0]),
            .count(count_r),
            .value(cc_val[k]),
            .event_r(ch_event[k]),
            .out_r(ch_out[k])
        );
    end

    // Sticky status, write one to clear, set wins
    always_comb
    begin
        status_nxt = status_r;
        if (hit(wa_en, wa_addr, `TMR_OFF_STATUS))
            status_nxt = status_nxt & ~wa_data[4:0];
        status_nxt = status_nxt | {ch_event, upd};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= 5'h00;
            irq_r <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask_r);
        end
    end

    halt_on_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (reload_r == '0 && !(wa_en && wa_addr == `TMR_OFF_COUNT) &&
            !(wb_en && wb_addr == `TMR_OFF_COUNT))
        |=> count_r == $past(count_r))
        else $error("counter moved while reload value was zero");

    upper_absent_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!WIDE_TIMER && state_r == BUS_SETUP && psel && penable &&
            !pwrite && addr == `TMR_OFF_RELOAD)
        |=> prdata_r[31:16] == 16'h0000)
        else $error("upper reload half present on narrow timer");

    burst_whole_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wa_en && is_burst && !byte_mode && tgt_a == `TMR_OFF_RELOAD)
        |=> reload_r[15:0] == $past(pwdata[15:0]))
        else $error("sixteen-bit burst item not delivered whole");

    burst_split_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wa_en && is_burst && byte_mode && b_ok &&
            tgt_b == `TMR_OFF_RELOAD)
        |=> reload_r == W'($past(pwdata[7:0])))
        else $error("low byte of burst item not in second register");

    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dctrl_r & ~`TMR_DCTRL_MASK) == 16'h0000)
        else $error("reserved burst control bits set");

    answer_once_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready_r |=> !pready_r)
        else $error("ready held for more than one cycle");
endmodule // timer_regs
`default_nettype wire

// ### core/tmr_consts.svh
/*
 * Offsets, field positions, reset values and masks of the timer
 * register block. Assumes byte addressing on a 32-bit APB bus.
 */
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_OFF_CTRL1 8'h00
`define TMR_OFF_MASK 8'h0C
`define TMR_OFF_STATUS 8'h10
`define TMR_OFF_MODE 8'h18
`define TMR_OFF_COUNT 8'h24
`define TMR_OFF_RELOAD 8'h2C
`define TMR_OFF_CC1 8'h34
`define TMR_OFF_CC2 8'h38
`define TMR_OFF_CC3 8'h3C
`define TMR_OFF_CC4 8'h40
`define TMR_OFF_DCTRL 8'h48
`define TMR_OFF_DATA 8'h4C

`define TMR_RELOAD_RST 32'h0000FFFF
`define TMR_CC_RST 32'h00000000
`define TMR_DCTRL_RST 16'h0000
`define TMR_DCTRL_MASK 16'h1F1F
`define TMR_MODE_MASK 32'h09090909

`define TMR_CTRL1_RUN_BIT 0
`define TMR_CTRL1_BYTE_BIT 1
`define TMR_MODE_IN_BIT 0
`define TMR_MODE_PRE_BIT 3
`define TMR_MODE_STRIDE 8
`define TMR_BASE_LSB 0
`define TMR_BASE_MSB 4
`define TMR_LEN_LSB 8
`define TMR_LEN_MSB 12

`endif

// ### core/tmr_types_pkg.sv
/*
 * Types shared by the timer register block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package tmr_types_pkg;
    typedef enum logic [1:0] {
        BUS_SETUP = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;
endpackage
`default_nettype wire

// ### test/apb_host_model.sv
/*
 * APB host model standing for the CPU and DMA controller.
 * Assumes a free-running pclk and a slave that raises pready.
 */
`default_nettype none
module apb_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // One transfer, held until pready
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_host_model
`default_nettype wire

// ### test/timer_reload_compare_dma_burst_test.sv
/*
 * Self-checking bench of the timer register block.
 * Assumes the APB host model and a narrow timer instance.
 */
`default_nettype none
module timer_reload_compare_dma_burst_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] capture_in, channel_out;
    int fails = 0;
    int compares = 0;
    timer_regs #(.WIDE_TIMER(1'b0), .ADDR_W(12)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_in(capture_in),
        .channel_out(channel_out), .irq(irq));
    apb_host_model u_host (
        .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b0, a, 32'h00000000, q, e);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask
    task automatic t_reset_narrow();
        rdchk(12'h02C, 32'h0000FFFF, 1'b0);
        for (int k = 0; k < 4; k++)
            rdchk(12'h034 + 12'(4 * k), 32'h00000000, 1'b0);
        rdchk(12'h048, 32'h00000000, 1'b0);
        wr(12'h034, 32'hFFFFFFFF);
        rdchk(12'h034, 32'h0000FFFF, 1'b0);
        wr(12'h048, 32'h0000FFFF);
        rdchk(12'h048, 32'h00001F1F, 1'b0);
        rdchk(12'h080, 32'h00000000, 1'b1);
        rdchk(12'h134, 32'h00000000, 1'b1);
    endtask
    task automatic t_halt();
        logic [31:0] q;
        logic e;
        wr(12'h02C, 32'h00000000);
        wr(12'h024, 32'h00000007);
        wr(12'h000, 32'h00000001);
        repeat (10) @(posedge pclk);
        rdchk(12'h024, 32'h00000007, 1'b0);
        wr(12'h02C, 32'h00000100);
        repeat (10) @(posedge pclk);
        u_host.xfer(1'b0, 12'h024, 32'h0, q, e);
        check(32'(q > 32'h7), 32'h1);
        wr(12'h000, 32'h00000000);
    endtask
    task automatic t_compare();
        wr(12'h018, 32'h00000000);
        wr(12'h024, 32'h00000005);
        for (int k = 0; k < 4; k++)
        begin
            wr(12'h034 + 12'(4 * k), 32'h0000000A);
            repeat (4) @(posedge pclk);
            check(32'(channel_out[k]), 32'h1);
            wr(12'h034 + 12'(4 * k), 32'h00000003);
            repeat (4) @(posedge pclk);
            check(32'(channel_out[k]), 32'h0);
        end
    endtask
    task automatic t_preload();
        wr(12'h018, 32'h00000008);
        wr(12'h034, 32'h0000000A);
        repeat (4) @(posedge pclk);
        check(32'(channel_out[0]), 32'h0);
        wr(12'h02C, 32'h00000006);
        wr(12'h000, 32'h00000001);
        repeat (8) @(posedge pclk);
        wr(12'h000, 32'h00000000);
        wr(12'h024, 32'h00000008);
        repeat (4) @(posedge pclk);
        check(32'(channel_out[0]), 32'h1);
    endtask
    task automatic t_capture_irq();
        wr(12'h02C, 32'h0000FFFF);
        wr(12'h018, 32'h01010101);
        wr(12'h010, 32'h0000001F);
        for (int k = 0; k < 4; k++)
        begin
            wr(12'h024, 32'h00000100 + 32'(k));
            capture_in <= 4'h1 << k;
            repeat (2) @(posedge pclk);
            capture_in <= 4'h0;
            repeat (8) @(posedge pclk);
            rdchk(12'h034 + 12'(4 * k), 32'h100 + 32'(k), 1'b0);
        end
        check(32'(irq), 32'h0);
        wr(12'h00C, 32'h0000001E);
        repeat (3) @(posedge pclk);
        check(32'(irq), 32'h1);
        rdchk(12'h010, 32'h0000001E, 1'b0);
        wr(12'h010, 32'h0000001E);
        repeat (3) @(posedge pclk);
        check(32'(irq), 32'h0);
    endtask
    task automatic t_burst();
        wr(12'h018, 32'h00000000);
        wr(12'h048, 32'h0000020D);
        for (int i = 0; i < 3; i++)
            wr(12'h04C, 32'h1111 * (i + 1));
        for (int i = 0; i < 3; i++)
            rdchk(12'h034 + 12'(4 * i), 32'h1111 * (i + 1), 1'b0);
        wr(12'h04C, 32'h00004444);
        rdchk(12'h034, 32'h00004444, 1'b0);
        wr(12'h048, 32'h00000000);
        wr(12'h04C, 32'h00000002);
        rdchk(12'h000, 32'h00000002, 1'b0);
        wr(12'h048, 32'h0000030D);
        wr(12'h04C, 32'h0000AABB);
        wr(12'h04C, 32'h0000CCDD);
        rdchk(12'h034, 32'h000000AA, 1'b0);
        rdchk(12'h038, 32'h000000BB, 1'b0);
        rdchk(12'h03C, 32'h000000CC, 1'b0);
        rdchk(12'h040, 32'h000000DD, 1'b0);
        wr(12'h048, 32'h0000030D);
        rdchk(12'h04C, 32'h0000AABB, 1'b0);
        wr(12'h048, 32'h0000010A);
        wr(12'h04C, 32'h00001234);
        rdchk(12'h02C, 32'h00000034, 1'b0);
        wr(12'h000, 32'h00000000);
        wr(12'h048, 32'h0000000B);
        wr(12'h04C, 32'h00005678);
        rdchk(12'h02C, 32'h00005678, 1'b0);
    endtask
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        capture_in = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_narrow();
        t_halt();
        t_compare();
        t_preload();
        t_capture_irq();
        t_burst();
        wrap_up();
    end
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule // timer_reload_compare_dma_burst_test
`default_nettype wire
